// *** src/chan_if.sv ***
`default_nettype none

interface chan_if;
    logic   rise_en;
    logic   fall_en;
    logic   invert;
    logic   result;
    logic   edge_evt;

    modport ctl  (output rise_en, output fall_en, output invert,
                  input result, input edge_evt);
    modport chan (input rise_en, input fall_en, input invert,
                  output result, output edge_evt);
endinterface : chan_if

`default_nettype wire

// *** src/cmp_channel.sv ***
`default_nettype none

module cmp_channel (
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic raw_async,
    chan_if.chan      ch
);
    logic   sync_a_r;
    logic   sync_b_r;
    logic   result_r;
    logic   result_nxt;
    logic   prev_r;
    wire    rise_seen;
    wire    fall_seen;

    // ------------------------------------------------------------------
    // decision sync, polarity and edge detection
    // ------------------------------------------------------------------
    assign result_nxt  = sync_b_r ^ ch.invert;
    assign rise_seen   = result_r & ~prev_r;
    assign fall_seen   = ~result_r & prev_r;
    assign ch.edge_evt = (rise_seen & ch.rise_en) | (fall_seen & ch.fall_en);
    assign ch.result   = result_r;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync_a_r <= 1'b0;
            sync_b_r <= 1'b0;
            result_r <= 1'b0;
            prev_r   <= 1'b0;
        end else begin
            sync_a_r <= raw_async;
            sync_b_r <= sync_a_r;
            result_r <= result_nxt;
            prev_r   <= result_r;
        end
    end
endmodule : cmp_channel

`default_nettype wire

// *** src/cmp_ctrl_top.sv ***
// The implementer's own choices: the placing of the registers and the APB interface to the registers.
`default_nettype none

module cmp_ctrl_top (
    input  wire logic                                   pclk,
    input  wire logic                                   presetn,
    input  wire logic                                   psel,
    input  wire logic                                   penable,
    input  wire logic                                   pwrite,
    input  wire logic [cmp_pkg::ADDR_W-1:0]             paddr,
    input  wire logic [cmp_pkg::DATA_W-1:0]             pwdata,
    output logic      [cmp_pkg::DATA_W-1:0]             prdata,
    output logic                                        pready,
    output logic                                        pslverr,
    input  wire logic [cmp_pkg::NUM_CMP-1:0]            cmp_raw_async,
    output logic      [cmp_pkg::NUM_CMP-1:0]            cmp_result_bit,
    output logic      [cmp_pkg::NUM_CMP-1:0][cmp_pkg::SEL_W-1:0]   pos_input_select,
    output logic      [cmp_pkg::NUM_CMP-1:0][cmp_pkg::SEL_W-1:0]   neg_input_select,
    output logic      [cmp_pkg::NUM_CMP-1:0][cmp_pkg::ROUTE_W-1:0] pos_route,
    output logic      [cmp_pkg::NUM_CMP-1:0][cmp_pkg::ROUTE_W-1:0] neg_route,
    output logic                                        irq
);
    import cmp_pkg::*;

    // ------------------------------------------------------------------
    // registers and decode
    // ------------------------------------------------------------------
    logic   [REG_W-1:0]     ctrl_r      [NUM_CMP];
    logic   [NUM_CMP-1:0]   invert_r;
    logic   [DATA_W-1:0]    prdata_r;
    logic   [DATA_W-1:0]    prdata_nxt;
    logic                   pslverr_r;
    logic   [NUM_CMP-1:0]   irq_status;
    logic   [NUM_CMP-1:0]   irq_mask;
    logic   [NUM_CMP-1:0]   edge_vec;

    wire                    setup_ph;
    wire                    wr_en;
    wire                    hit_ctrl_one;
    wire                    hit_ctrl_two;
    wire                    hit_mirror;
    wire                    hit_invert;
    wire                    hit_stat;
    wire                    hit_mask;
    wire                    hit_any;
    wire    [REG_W-1:0]     wr_byte;
    wire    [REG_W-1:0]     ctrl_wr_val;
    wire    [REG_W-1:0]     mirror_val;

    assign setup_ph     = psel & ~penable;
    assign wr_en        = psel & penable & pwrite;
    assign hit_ctrl_one = (paddr == OFS_CTRL_ONE);
    assign hit_ctrl_two = (paddr == OFS_CTRL_TWO);
    assign hit_mirror   = (paddr == OFS_MIRROR);
    assign hit_invert   = (paddr == OFS_INVERT);
    assign hit_stat     = (paddr == OFS_IRQ_STAT);
    assign hit_mask     = (paddr == OFS_IRQ_MASK);
    assign hit_any      = hit_ctrl_one | hit_ctrl_two | hit_mirror
                        | hit_invert | hit_stat | hit_mask;
    assign wr_byte      = pwdata[REG_W-1:0];
    assign ctrl_wr_val  = wr_byte & CTRL_WMASK;
    assign mirror_val   = {{(REG_W-NUM_CMP){1'b0}}, cmp_result_bit};

    // zero wait states; the answer is prepared in the setup cycle
    assign pready  = 1'b1;
    assign prdata  = prdata_r;
    assign pslverr = pslverr_r;

    // ------------------------------------------------------------------
    // read mux
    // ------------------------------------------------------------------
    always_comb begin
        prdata_nxt = '0;
        if (hit_ctrl_one) begin
            prdata_nxt[REG_W-1:0] = ctrl_r[0] & CTRL_WMASK;
        end else if (hit_ctrl_two) begin
            prdata_nxt[REG_W-1:0] = ctrl_r[1] & CTRL_WMASK;
        end else if (hit_mirror) begin
            prdata_nxt[REG_W-1:0] = mirror_val;
        end else if (hit_invert) begin
            prdata_nxt[NUM_CMP-1:0] = invert_r;
        end else if (hit_stat) begin
            prdata_nxt[NUM_CMP-1:0] = irq_status;
        end else if (hit_mask) begin
            prdata_nxt[NUM_CMP-1:0] = irq_mask;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_r  <= '0;
            pslverr_r <= 1'b0;
        end else if (setup_ph) begin
            prdata_r  <= pwrite ? '0 : prdata_nxt;
            pslverr_r <= ~hit_any | (pwrite & hit_mirror);
        end
    end

    // ------------------------------------------------------------------
    // control registers
    // ------------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_r[0] <= CTRL_RST;
            ctrl_r[1] <= CTRL_RST;
            invert_r  <= INVERT_RST;
        end else if (wr_en) begin
            if (hit_ctrl_one) begin
                ctrl_r[0] <= ctrl_wr_val;
            end
            if (hit_ctrl_two) begin
                ctrl_r[1] <= ctrl_wr_val;
            end
            if (hit_invert) begin
                invert_r <= wr_byte[NUM_CMP-1:0];
            end
        end
    end

    // ------------------------------------------------------------------
    // comparator channels and input routing
    // ------------------------------------------------------------------
    chan_if ch [NUM_CMP] ();

    for (genvar g = 0; g < NUM_CMP; g++) begin : g_chan
        assign ch[g].rise_en   = ctrl_r[g][BIT_RISE_EN];
        assign ch[g].fall_en   = ctrl_r[g][BIT_FALL_EN];
        assign ch[g].invert    = invert_r[g];
        assign edge_vec[g]     = ch[g].edge_evt;
        assign cmp_result_bit[g]   = ch[g].result;
        assign pos_input_select[g] = ctrl_r[g][POS_SEL_HI:POS_SEL_LO];
        assign neg_input_select[g] = ctrl_r[g][NEG_SEL_HI:NEG_SEL_LO];
        // one-hot switch enables for the analog muxes
        assign pos_route[g] = ROUTE_ONE_HOT << pos_input_select[g];
        assign neg_route[g] = ROUTE_ONE_HOT << neg_input_select[g];

        cmp_channel u_chan (
            .pclk      (pclk),
            .presetn   (presetn),
            .raw_async (cmp_raw_async[g]),
            .ch        (ch[g])
        );
    end

    // ------------------------------------------------------------------
    // interrupt flags
    // ------------------------------------------------------------------
    irq_bank #(
        .N (NUM_CMP)
    ) u_irq (
        .pclk      (pclk),
        .presetn   (presetn),
        .set_evt   (edge_vec),
        .clr_wr    (wr_en & hit_stat),
        .clr_data  (wr_byte[NUM_CMP-1:0]),
        .mask_wr   (wr_en & hit_mask),
        .mask_data (wr_byte[NUM_CMP-1:0]),
        .status    (irq_status),
        .mask      (irq_mask),
        .irq       (irq)
    );

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    wire    res_one = cmp_result_bit[0];
    wire    res_two = cmp_result_bit[1];
    wire    clr_one = wr_en & hit_stat & wr_byte[0];
    wire    clr_two = wr_en & hit_stat & wr_byte[1];

    sequence s_read_setup(logic [7:0] ofs);
        psel && !penable && !pwrite && paddr == ofs;
    endsequence

    sequence s_steady_one;
        ($stable(cmp_raw_async[0]) && $stable(invert_r[0])) [*3];
    endsequence

    sequence s_steady_two;
        ($stable(cmp_raw_async[1]) && $stable(invert_r[1])) [*3];
    endsequence

    sequence s_write(logic [7:0] ofs);
        psel && penable && pwrite && paddr == ofs;
    endsequence

    a_rise_sets_flag: assert property (
        $rose(res_one) && ctrl_r[0][BIT_RISE_EN] |=> irq_status[0])
        else $error("rising edge did not set flag");

    a_rise_no_flag: assert property (
        !irq_status[0] && $rose(res_one) && !ctrl_r[0][BIT_RISE_EN] |=> !irq_status[0])
        else $error("rising edge set flag while disabled");

    a_fall_sets_flag: assert property (
        $fell(res_two) && ctrl_r[1][BIT_FALL_EN] |=> irq_status[1])
        else $error("falling edge did not set flag");

    a_fall_no_flag: assert property (
        !irq_status[1] && $fell(res_two) && !ctrl_r[1][BIT_FALL_EN] |=> !irq_status[1])
        else $error("falling edge set flag while disabled");

    a_pos_route_map: assert property (
        pos_input_select[0] == POS_FIXED |-> pos_route[0] == (ROUTE_ONE_HOT << ROUTE_FIXED))
        else $error("positive route wrong for fixed reference");

    a_sel_after_write: assert property (
        wr_en && hit_ctrl_two |=>
            neg_input_select[1] == $past(wr_byte[NEG_SEL_HI:NEG_SEL_LO]) &&
            neg_route[1] == (ROUTE_ONE_HOT << $past(wr_byte[NEG_SEL_HI:NEG_SEL_LO])))
        else $error("negative selector not taken from write");

    a_unimpl_zero: assert property (
        s_read_setup(OFS_CTRL_ONE) |=> prdata[3:2] == 2'h0 && ctrl_r[0][3:2] == 2'h0)
        else $error("unimplemented control bits not zero");

    a_mirror_read: assert property (
        s_read_setup(OFS_MIRROR) |=>
            prdata == {{(DATA_W-NUM_CMP){1'b0}}, $past(res_two), $past(res_one)})
        else $error("mirror read wrong");

    a_invert_path: assert property (
        s_steady_one |-> res_one == (cmp_raw_async[0] ^ invert_r[0]))
        else $error("result does not follow raw decision and polarity");

    a_flag_sticky: assert property (
        irq_status[0] && !clr_one |=> irq_status[0])
        else $error("flag dropped without clear");

    a_rise_sets_two: assert property (
        $rose(res_two) && ctrl_r[1][BIT_RISE_EN] |=> irq_status[1])
        else $error("rising edge did not set flag two");

    a_rise_no_two: assert property (
        !irq_status[1] && $rose(res_two) && !ctrl_r[1][BIT_RISE_EN] |=> !irq_status[1])
        else $error("rising edge set flag two while disabled");

    a_fall_sets_one: assert property (
        $fell(res_one) && ctrl_r[0][BIT_FALL_EN] |=> irq_status[0])
        else $error("falling edge did not set flag one");

    a_fall_no_one: assert property (
        !irq_status[0] && $fell(res_one) && !ctrl_r[0][BIT_FALL_EN] |=> !irq_status[0])
        else $error("falling edge set flag one while disabled");

    a_edge_needs_change: assert property (
        edge_vec[0] |-> $changed(res_one))
        else $error("flag event without result change");

    a_edge_sets_two: assert property (
        edge_vec[1] |=> irq_status[1])
        else $error("flag event lost");

    a_clear_w1c: assert property (
        clr_one && !edge_vec[0] |=> !irq_status[0])
        else $error("flag not cleared by write of one");

    a_flag_sticky_two: assert property (
        irq_status[1] && !clr_two |=> irq_status[1])
        else $error("flag two dropped without clear");

    a_invert_path_two: assert property (
        s_steady_two |-> res_two == (cmp_raw_async[1] ^ invert_r[1]))
        else $error("result two does not follow raw decision and polarity");

    a_ctrl_enables: assert property (
        s_write(OFS_CTRL_ONE) |=>
            ctrl_r[0][BIT_RISE_EN] == $past(wr_byte[BIT_RISE_EN]) &&
            ctrl_r[0][BIT_FALL_EN] == $past(wr_byte[BIT_FALL_EN]))
        else $error("edge enables not taken from write");

    a_pos_sel_write: assert property (
        s_write(OFS_CTRL_ONE) |=>
            pos_input_select[0] == $past(wr_byte[POS_SEL_HI:POS_SEL_LO]))
        else $error("positive selector not taken from write");

    a_ctrl_hold: assert property (
        !(wr_en && hit_ctrl_one) |=> $stable(ctrl_r[0]))
        else $error("control register one changed without write");

    a_unimpl_store: assert property (
        ctrl_r[0][3:2] == 2'h0 && ctrl_r[1][3:2] == 2'h0)
        else $error("unimplemented control bits stored");

    a_unimpl_two: assert property (
        s_read_setup(OFS_CTRL_TWO) |=> prdata[3:2] == 2'h0 && prdata[DATA_W-1:REG_W] == '0)
        else $error("control two read shows unimplemented bits");

    a_pos_route_pin: assert property (
        pos_input_select[0] == POS_PIN |-> pos_route[0] == (ROUTE_ONE_HOT << ROUTE_PIN))
        else $error("positive route wrong for pin");

    a_pos_route_dac: assert property (
        pos_input_select[0] == POS_DAC |-> pos_route[0] == (ROUTE_ONE_HOT << ROUTE_DAC))
        else $error("positive route wrong for converter reference");

    a_pos_route_gnd: assert property (
        pos_input_select[1] == POS_GND |-> pos_route[1] == (ROUTE_ONE_HOT << ROUTE_GND))
        else $error("positive route wrong for ground");

    a_pos_route_fix: assert property (
        pos_input_select[1] == POS_FIXED |-> pos_route[1] == (ROUTE_ONE_HOT << ROUTE_FIXED))
        else $error("positive route two wrong for fixed reference");

    a_neg_route_pick: assert property (
        neg_route[0][neg_input_select[0]] && neg_route[1][neg_input_select[1]])
        else $error("negative route misses selected pin");

    a_route_onehot: assert property (
        $onehot(pos_route[0]) && $onehot(pos_route[1]) &&
        $onehot(neg_route[0]) && $onehot(neg_route[1]))
        else $error("route not one-hot");

    a_unmapped_err: assert property (
        setup_ph && !hit_any |=> pslverr)
        else $error("unmapped access without error");

    a_unmapped_zero: assert property (
        setup_ph && !pwrite && !hit_any |=> prdata == '0)
        else $error("unmapped read not zero");

    a_mirror_wr_err: assert property (
        setup_ph && pwrite && hit_mirror |=> pslverr)
        else $error("mirror write not refused");

    a_prdata_holds: assert property (
        !setup_ph |=> $stable(prdata) && $stable(pslverr))
        else $error("read answer changed outside setup");

    a_mask_write: assert property (
        s_write(OFS_IRQ_MASK) |=> irq_mask == $past(wr_byte[NUM_CMP-1:0]))
        else $error("mask not taken from write");

    a_reset_clears: assert property (
        disable iff (1'b0) $rose(presetn) |->
            ctrl_r[0] == CTRL_RST && ctrl_r[1] == CTRL_RST && cmp_result_bit == '0 &&
            irq_status == IRQ_RST && prdata == '0 && !irq)
        else $error("state not cleared by reset");

endmodule : cmp_ctrl_top

`default_nettype wire

// *** src/cmp_pkg.sv ***
`default_nettype none

package cmp_pkg;

    // ------------------------------------------------------------------
    // bus geometry
    // ------------------------------------------------------------------
    localparam int          ADDR_W        = 8;
    localparam int          DATA_W        = 32;
    localparam int          REG_W         = 8;
    localparam int          NUM_CMP       = 2;

    // ------------------------------------------------------------------
    // register byte offsets
    // ------------------------------------------------------------------
    localparam logic [7:0]  OFS_CTRL_ONE  = 8'h00;
    localparam logic [7:0]  OFS_CTRL_TWO  = 8'h04;
    localparam logic [7:0]  OFS_MIRROR    = 8'h08;
    localparam logic [7:0]  OFS_INVERT    = 8'h0C;
    localparam logic [7:0]  OFS_IRQ_STAT  = 8'h10;
    localparam logic [7:0]  OFS_IRQ_MASK  = 8'h14;

    // ------------------------------------------------------------------
    // control register fields, shared by control registers one and two
    // ------------------------------------------------------------------
    localparam int          BIT_RISE_EN   = 7;
    localparam int          BIT_FALL_EN   = 6;
    localparam int          POS_SEL_HI    = 5;
    localparam int          POS_SEL_LO    = 4;
    localparam int          NEG_SEL_HI    = 1;
    localparam int          NEG_SEL_LO    = 0;
    localparam int          SEL_W         = 2;
    localparam int          ROUTE_W       = 4;
    localparam logic [7:0]  CTRL_WMASK    = 8'hF3;
    localparam logic [7:0]  CTRL_RST      = 8'h00;
    localparam logic [1:0]  INVERT_RST    = 2'h0;
    localparam logic [1:0]  IRQ_RST       = 2'h0;
    localparam logic [3:0]  ROUTE_ONE_HOT = 4'h1;

    // positive input selector codes
    localparam logic [1:0]  POS_PIN       = 2'h0;
    localparam logic [1:0]  POS_DAC       = 2'h1;
    localparam logic [1:0]  POS_FIXED     = 2'h2;
    localparam logic [1:0]  POS_GND       = 2'h3;

    // route bit positions in the positive one-hot route
    localparam int          ROUTE_PIN     = 0;
    localparam int          ROUTE_DAC     = 1;
    localparam int          ROUTE_FIXED   = 2;
    localparam int          ROUTE_GND     = 3;

endpackage : cmp_pkg

`default_nettype wire

// *** src/irq_bank.sv ***
`default_nettype none

module irq_bank #(
    parameter int N = 2
) (
    input  wire logic         pclk,
    input  wire logic         presetn,
    input  wire logic [N-1:0] set_evt,
    input  wire logic         clr_wr,
    input  wire logic [N-1:0] clr_data,
    input  wire logic         mask_wr,
    input  wire logic [N-1:0] mask_data,
    output logic      [N-1:0] status,
    output logic      [N-1:0] mask,
    output logic              irq
);
    logic   [N-1:0] status_r;
    logic   [N-1:0] status_nxt;
    logic   [N-1:0] mask_r;
    wire    [N-1:0] clr_bits;

    // a set in the clearing cycle wins
    assign clr_bits   = clr_wr ? clr_data : '0;
    assign status_nxt = set_evt | (status_r & ~clr_bits);
    assign status     = status_r;
    assign mask       = mask_r;
    assign irq        = |(status_r & mask_r);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            status_r <= '0;
            mask_r   <= '0;
        end else begin
            status_r <= status_nxt;
            if (mask_wr) begin
                mask_r <= mask_data;
            end
        end
    end
endmodule : irq_bank

`default_nettype wire

// *** tb/tb.sv ***
`default_nettype none

module tb
    import cmp_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    // ------------------------------------------------------------------
    // signals
    // ------------------------------------------------------------------
    logic                                 pclk;
    logic                                 presetn;
    logic                                 psel;
    logic                                 penable;
    logic                                 pwrite;
    logic [ADDR_W-1:0]                    paddr;
    logic [DATA_W-1:0]                    pwdata;
    logic [DATA_W-1:0]                    prdata;
    logic                                 pready;
    logic                                 pslverr;
    logic [NUM_CMP-1:0]                   raw;
    logic [NUM_CMP-1:0]                   cmp_result_bit;
    logic [NUM_CMP-1:0][SEL_W-1:0]        pos_input_select;
    logic [NUM_CMP-1:0][SEL_W-1:0]        neg_input_select;
    logic [NUM_CMP-1:0][ROUTE_W-1:0]      pos_route;
    logic [NUM_CMP-1:0][ROUTE_W-1:0]      neg_route;
    logic                                 irq;
    int                                   error_cnt;
    int                                   tests_run;

    cmp_ctrl_top i_cmp_ctrl_top (
        .pclk             (pclk),
        .presetn          (presetn),
        .psel             (psel),
        .penable          (penable),
        .pwrite           (pwrite),
        .paddr            (paddr),
        .pwdata           (pwdata),
        .prdata           (prdata),
        .pready           (pready),
        .pslverr          (pslverr),
        .cmp_raw_async    (raw),
        .cmp_result_bit   (cmp_result_bit),
        .pos_input_select (pos_input_select),
        .neg_input_select (neg_input_select),
        .pos_route        (pos_route),
        .neg_route        (neg_route),
        .irq              (irq)
    );

    always #5 pclk = ~pclk;

    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    function automatic logic [31:0] exp_route(input logic [1:0] c);
        return 32'(4'h1 << c);
    endfunction : exp_route

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            $display("ERROR %s expected %h seen %h", name, exp, got);
            error_cnt++;
        end
    endtask : chk

    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] rd, output logic err);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        // let the access edge settle before callers look at outputs
        @(posedge pclk);
    endtask : apb

    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic e);
        logic [31:0] rd;
        logic        err;
        apb(1'b1, a, d, rd, err);
        chk("write pslverr", 32'(e), 32'(err));
    endtask : wr

    task automatic chk_rd(input logic [7:0] a, input logic [31:0] exp, input logic e);
        logic [31:0] rd;
        logic        err;
        apb(1'b0, a, 32'h0, rd, err);
        chk($sformatf("read %h", a), exp, rd);
        chk("read pslverr", 32'(e), 32'(err));
    endtask : chk_rd

    task automatic settle();
        repeat (6) @(posedge pclk);
    endtask : settle

    task automatic check_reset();
        for (int a = 0; a < 6; a++) chk_rd(8'(a * 4), 32'h0, 1'b0);
        chk("pos_route", 32'h11, 32'(pos_route));
        chk("neg_route", 32'h11, 32'(neg_route));
        chk("irq", 32'h0, 32'(irq));
        chk("result", 32'h0, 32'(cmp_result_bit));
    endtask : check_reset

    task automatic do_ctrl(input int i, input logic [7:0] d);
        wr(8'(i * 4), 32'(d), 1'b0);
        chk_rd(8'(i * 4), 32'(d & 8'hF3), 1'b0);
        chk("pos_sel", 32'(d[5:4]), 32'(pos_input_select[i]));
        chk("pos_route", exp_route(d[5:4]), 32'(pos_route[i]));
        chk("neg_sel", 32'(d[1:0]), 32'(neg_input_select[i]));
        chk("neg_route", exp_route(d[1:0]), 32'(neg_route[i]));
    endtask : do_ctrl

    task automatic results();
        $display("comparisons %0d mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : results

    // ------------------------------------------------------------------
    // watchdog
    // ------------------------------------------------------------------
    initial begin
        #200000;
        error_cnt++;
        results();
    end

    // ------------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------------
    initial begin
        logic [1:0] r;
        logic [1:0] v;
        pclk = 1'b0;
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = '0;
        pwdata = '0;
        raw = '0;
        error_cnt = 0;
        tests_run = 0;
        void'($urandom(32'hE620F79A));
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        check_reset();
        // every selector code, with the unimplemented bits written as ones
        for (int i = 0; i < 2; i++) begin
            for (int c = 0; c < 4; c++) do_ctrl(i, {2'b00, c[1:0], 2'b11, c[1:0]});
        end
        repeat (8) do_ctrl($urandom_range(1, 0), 8'($urandom));
        // result path and mirror, edge enables off so no flag may appear
        do_ctrl(0, 8'h00);
        do_ctrl(1, 8'h00);
        repeat (8) begin
            r = 2'($urandom);
            v = 2'($urandom);
            wr(OFS_INVERT, 32'(v), 1'b0);
            raw <= r;
            settle();
            chk("result", 32'(r ^ v), 32'(cmp_result_bit));
            chk_rd(OFS_MIRROR, 32'(r ^ v), 1'b0);
            chk_rd(OFS_IRQ_STAT, 32'h0, 1'b0);
        end
        // edge-selective flags per comparator
        for (int i = 0; i < 2; i++) begin
            wr(OFS_INVERT, 32'h0, 1'b0);
            raw <= 2'b00;
            settle();
            wr(OFS_IRQ_MASK, 32'h3, 1'b0);
            wr(OFS_IRQ_STAT, 32'h3, 1'b0);
            wr(8'(i * 4), 32'h80, 1'b0);
            raw[i] <= 1'b1;
            settle();
            chk_rd(OFS_IRQ_STAT, 32'(1 << i), 1'b0);
            chk("irq", 32'h1, 32'(irq));
            settle();
            chk_rd(OFS_IRQ_STAT, 32'(1 << i), 1'b0);
            wr(OFS_IRQ_STAT, 32'(1 << i), 1'b0);
            chk_rd(OFS_IRQ_STAT, 32'h0, 1'b0);
            chk("irq", 32'h0, 32'(irq));
            raw[i] <= 1'b0;
            settle();
            chk_rd(OFS_IRQ_STAT, 32'h0, 1'b0);
            wr(8'(i * 4), 32'h40, 1'b0);
            raw[i] <= 1'b1;
            settle();
            chk_rd(OFS_IRQ_STAT, 32'h0, 1'b0);
            raw[i] <= 1'b0;
            settle();
            chk_rd(OFS_IRQ_STAT, 32'(1 << i), 1'b0);
            wr(OFS_IRQ_MASK, 32'h0, 1'b0);
            chk("irq", 32'h0, 32'(irq));
            wr(OFS_IRQ_MASK, 32'h3, 1'b0);
            chk("irq", 32'h1, 32'(irq));
            wr(OFS_IRQ_STAT, 32'h3, 1'b0);
        end
        // refused accesses
        raw <= 2'b10;
        settle();
        chk_rd(8'h18, 32'h0, 1'b1);
        wr(OFS_MIRROR, 32'hFF, 1'b1);
        chk_rd(OFS_MIRROR, 32'h2, 1'b0);
        // second reset in mid-run
        raw <= 2'b00;
        do_ctrl(0, 8'hF3);
        wr(OFS_IRQ_MASK, 32'h3, 1'b0);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        check_reset();
        results();
    end

endmodule : tb

`default_nettype wire
